// File: camtrig_pkg.sv
`default_nettype none
package camtrig_pkg;
	localparam int unsigned ADDR_W     = 5;
	localparam logic [4:0]  CTRL_OFS   = 5'h00;
	localparam logic [4:0]  EXPO_OFS   = 5'h04;
	localparam logic [4:0]  RDLEN_OFS  = 5'h08;
	localparam logic [4:0]  SWTRIG_OFS = 5'h0C;
	localparam logic [4:0]  STATUS_OFS = 5'h10;
	localparam int unsigned CTRL_W     = 6;
	localparam int unsigned MODE_LSB   = 0;
	localparam int unsigned POL_BIT    = 2;
	localparam int unsigned SEL_BIT    = 3;
	localparam int unsigned BIN_LSB    = 4;
	localparam logic [5:0]  CTRL_RST   = 6'h05;
	localparam int unsigned CNT_W      = 24;
	localparam logic [23:0] EXPO_RST   = 24'h0003E8;
	localparam logic [23:0] RDLEN_RST  = 24'h0007D0;
	localparam int unsigned FRM_W      = 16;
	localparam int unsigned PIX_W      = 12;
	localparam int unsigned SUM_W      = 18;
	localparam int unsigned LINE_W     = 2048;
	localparam int unsigned COL_W      = 11;
	typedef enum logic [1:0] {
		free_run_mode            = 2'b00,
		edge_trigger_mode        = 2'b01,
		pulse_width_trigger_mode = 2'b10,
		software_trigger_mode    = 2'b11
	} trig_mode_t;
	typedef enum logic [1:0] {
		st_idle    = 2'b00,
		st_expose  = 2'b01,
		st_readout = 2'b10
	} cam_state_t;
endpackage
`default_nettype wire

// File: pixel_binner.sv
`default_nettype none
module pixel_binner
	import camtrig_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire logic [1:0]       bin_log2,
	input  wire logic             pix_sof,
	input  wire logic             pix_valid,
	input  wire logic [PIX_W-1:0] pix_data,
	input  wire logic             pix_eol,
	output logic                  bin_valid,
	output logic [SUM_W-1:0]      bin_data
);
	logic [SUM_W-1:0] linebuf [LINE_W];
	logic [2:0]       px_r, px_nxt, row_r, row_nxt, last;
	logic [COL_W-1:0] col_r, col_nxt;
	logic [SUM_W-1:0] hacc_r, hacc_nxt, hsum, vsum, wr_data, out_r, out_nxt;
	logic             wr_en, vld_r, vld_nxt, grp_end;
	logic [3:0]       size;

	always_comb begin
		size    = 4'h1 << bin_log2;
		last    = 3'(size - 4'h1);
		hsum    = hacc_r + {{(SUM_W-PIX_W){1'b0}}, pix_data};
		vsum    = ((row_r == 3'h0) ? {SUM_W{1'b0}} : linebuf[col_r]) + hsum;
		grp_end = (px_r == last);
		px_nxt  = px_r;
		row_nxt = row_r;
		col_nxt = col_r;
		hacc_nxt = hacc_r;
		vld_nxt = 1'b0;
		out_nxt = out_r;
		wr_en   = 1'b0;
		wr_data = vsum;
		if (pix_sof) begin
			px_nxt   = 3'h0;
			row_nxt  = 3'h0;
			col_nxt  = {COL_W{1'b0}};
			hacc_nxt = {SUM_W{1'b0}};
		end else if (pix_valid) begin
			if (grp_end) begin
				col_nxt  = col_r + 1'b1;
				px_nxt   = 3'h0;
				hacc_nxt = {SUM_W{1'b0}};
				if (row_r == last) begin
					vld_nxt = 1'b1;
					out_nxt = vsum;
				end else begin
					wr_en = 1'b1;
				end
			end else begin
				px_nxt   = px_r + 3'h1;
				hacc_nxt = hsum;
			end
			if (pix_eol) begin
				col_nxt  = {COL_W{1'b0}};
				px_nxt   = 3'h0;
				hacc_nxt = {SUM_W{1'b0}};
				row_nxt  = (row_r == last) ? 3'h0 : row_r + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			px_r   <= 3'h0;
			row_r  <= 3'h0;
			col_r  <= {COL_W{1'b0}};
			hacc_r <= {SUM_W{1'b0}};
			vld_r  <= 1'b0;
			out_r  <= {SUM_W{1'b0}};
		end else begin
			px_r   <= px_nxt;
			row_r  <= row_nxt;
			col_r  <= col_nxt;
			hacc_r <= hacc_nxt;
			vld_r  <= vld_nxt;
			out_r  <= out_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			linebuf[col_r] <= wr_data;
		end
	end

	assign bin_valid = vld_r;
	assign bin_data  = out_r;

	a_bin_block_end: assert property (@(posedge core_clk) disable iff (!arst_n)
		vld_r |-> $past(pix_valid && !pix_sof && px_r == last && row_r == last))
		else $error("binned pixel without a complete block");
	c_bin_out: cover property (@(posedge core_clk) disable iff (!arst_n) vld_r && bin_log2 == 2'h1);
endmodule
`default_nettype wire

// File: camera_trigger_sync_port.sv
// The register addresses and register access over Avalon-MM were decided locally.
`default_nettype none
module camera_trigger_sync_port
	import camtrig_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              trig_in_n,
	output logic                   readout_sync,
	output logic                   status_sync,
	input  wire logic              pix_sof,
	input  wire logic              pix_valid,
	input  wire logic [PIX_W-1:0]  pix_data,
	input  wire logic              pix_eol,
	output logic                   bin_valid,
	output logic [SUM_W-1:0]       bin_data
);
	logic              sync1_r, sync2_r, prev_r, trig_on, edge_hit, pulse_on, pol, sel;
	trig_mode_t        mode_w;
	cam_state_t        state_r, state_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt, expo_r, expo_nxt, rdlen_r, rdlen_nxt;
	logic [FRM_W-1:0]  frm_r, frm_nxt;
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [31:0]       rdata_r, rdata_nxt, merged;
	logic              wait_r, wait_nxt, soft_r, soft_nxt, ro_r, ro_nxt, sb_r, sb_nxt;
	logic              req, commit, sw_hit, expo_done, ro_done, start;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction

	// trigger pin synchroniser and edge history
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			prev_r  <= 1'b0;
		end else begin
			sync1_r <= trig_in_n;
			sync2_r <= sync1_r;
			prev_r  <= trig_on;
		end
	end

	always_comb begin
		mode_w   = trig_mode_t'(ctrl_r[MODE_LSB +: 2]);
		pol      = ctrl_r[POL_BIT];
		sel      = ctrl_r[SEL_BIT];
		trig_on  = ~sync2_r;
		pulse_on = (trig_on == pol);
		edge_hit = pulse_on & (prev_r != pol);
	end

	// register bus
	always_comb begin
		req       = avs_read | avs_write;
		commit    = req & ~wait_r;
		wait_nxt  = ~(req & wait_r);
		rdata_nxt = rdata_r;
		ctrl_nxt  = ctrl_r;
		expo_nxt  = expo_r;
		rdlen_nxt = rdlen_r;
		sw_hit    = 1'b0;
		merged    = 32'h00000000;
		if (req & wait_r & avs_read) begin
			if (avs_address == CTRL_OFS) begin
				rdata_nxt = {{(32-CTRL_W){1'b0}}, ctrl_r};
			end else if (avs_address == EXPO_OFS) begin
				rdata_nxt = {{(32-CNT_W){1'b0}}, expo_r};
			end else if (avs_address == RDLEN_OFS) begin
				rdata_nxt = {{(32-CNT_W){1'b0}}, rdlen_r};
			end else if (avs_address == STATUS_OFS) begin
				rdata_nxt = {frm_r, 11'h000, sb_r, ro_r, trig_on, state_r};
			end else begin
				rdata_nxt = 32'h00000000;
			end
		end
		if (commit & avs_write) begin
			if (avs_address == CTRL_OFS) begin
				merged   = be_merge({{(32-CTRL_W){1'b0}}, ctrl_r}, avs_writedata, avs_byteenable);
				ctrl_nxt = merged[CTRL_W-1:0];
			end else if (avs_address == EXPO_OFS) begin
				merged   = be_merge({{(32-CNT_W){1'b0}}, expo_r}, avs_writedata, avs_byteenable);
				expo_nxt = merged[CNT_W-1:0];
			end else if (avs_address == RDLEN_OFS) begin
				merged    = be_merge({{(32-CNT_W){1'b0}}, rdlen_r}, avs_writedata, avs_byteenable);
				rdlen_nxt = merged[CNT_W-1:0];
			end else if (avs_address == SWTRIG_OFS) begin
				sw_hit = avs_byteenable[0] & avs_writedata[0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h00000000;
			ctrl_r  <= CTRL_RST;
			expo_r  <= EXPO_RST;
			rdlen_r <= RDLEN_RST;
		end else begin
			wait_r  <= wait_nxt;
			rdata_r <= rdata_nxt;
			ctrl_r  <= ctrl_nxt;
			expo_r  <= expo_nxt;
			rdlen_r <= rdlen_nxt;
		end
	end

	// exposure and readout sequencer
	always_comb begin
		expo_done = ({1'b0, cnt_r} + 25'h0000001) >= {1'b0, expo_r};
		ro_done   = ({1'b0, cnt_r} + 25'h0000001) >= {1'b0, rdlen_r};
		soft_nxt  = sw_hit;
		start     = 1'b0;
		case (mode_w)
			free_run_mode:            start = 1'b1;
			edge_trigger_mode:        start = edge_hit;
			pulse_width_trigger_mode: start = edge_hit;
			software_trigger_mode:    start = soft_r;
			default:                  start = 1'b0;
		endcase
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		frm_nxt   = frm_r;
		case (state_r)
			st_idle: begin
				if (start) begin
					state_nxt = st_expose;
					cnt_nxt   = {CNT_W{1'b0}};
				end
			end
			st_expose: begin
				cnt_nxt = cnt_r + 24'h000001;
				if ((mode_w == pulse_width_trigger_mode) ? !pulse_on : expo_done) begin
					state_nxt = st_readout;
					cnt_nxt   = {CNT_W{1'b0}};
				end
			end
			st_readout: begin
				cnt_nxt = cnt_r + 24'h000001;
				if (ro_done) begin
					state_nxt = st_idle;
					frm_nxt   = frm_r + 16'h0001;
				end
			end
			default: begin
				state_nxt = st_idle;
			end
		endcase
		ro_nxt = (state_nxt == st_readout);
		sb_nxt = sel ? (state_nxt != st_idle) : (state_nxt == st_expose);
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= st_idle;
			cnt_r   <= {CNT_W{1'b0}};
			frm_r   <= {FRM_W{1'b0}};
			soft_r  <= 1'b0;
			ro_r    <= 1'b0;
			sb_r    <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			frm_r   <= frm_nxt;
			soft_r  <= soft_nxt;
			ro_r    <= ro_nxt;
			sb_r    <= sb_nxt;
		end
	end

	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = wait_r;
	assign readout_sync    = ro_r;
	assign status_sync     = sb_r;

	pixel_binner u_binner (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.bin_log2  (ctrl_r[BIN_LSB +: 2]),
		.pix_sof   (pix_sof),
		.pix_valid (pix_valid),
		.pix_data  (pix_data),
		.pix_eol   (pix_eol),
		.bin_valid (bin_valid),
		.bin_data  (bin_data)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_trig_sync_path: assert property ($past(arst_n, 2) |-> trig_on == ~$past(trig_in_n, 2))
		else $error("trigger not two stages behind pin");
	a_readout_level: assert property (readout_sync == (state_r == st_readout))
		else $error("readout output disagrees with readout state");
	a_expose_window: assert property (!$past(sel) |-> status_sync == (state_r == st_expose))
		else $error("exposure output disagrees with exposure");
	a_lockout_window: assert property ($past(sel) |-> status_sync == (state_r != st_idle))
		else $error("lockout output disagrees with busy state");
	a_lockout_ignore: assert property (state_r == st_readout |=> state_r != st_expose)
		else $error("trigger accepted while locked out");
	a_expo_hold: assert property (state_r == st_expose && mode_w != pulse_width_trigger_mode && !expo_done
		|=> state_r == st_expose && cnt_r == $past(cnt_r) + 24'h000001)
		else $error("exposure ended early");
	a_expo_end: assert property (state_r == st_expose && mode_w != pulse_width_trigger_mode && expo_done
		|=> state_r == st_readout && cnt_r == 24'h000000)
		else $error("exposure overran programmed count");
	a_edge_start: assert property (state_r == st_idle && mode_w == edge_trigger_mode && edge_hit
		|=> state_r == st_expose)
		else $error("edge trigger missed");
	a_pulse_len: assert property (state_r == st_expose && mode_w == pulse_width_trigger_mode
		|=> state_r == ($past(pulse_on) ? st_expose : st_readout))
		else $error("pulse exposure not following trigger level");
	a_soft_start: assert property (sw_hit && state_r == st_idle && mode_w == software_trigger_mode
		|-> ##2 state_r == st_expose)
		else $error("software trigger missed");
	a_bus_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered in one cycle");

	c_edge_frame: cover property (mode_w == edge_trigger_mode && state_r == st_readout ##1 state_r == st_idle);
	c_pulse_frame: cover property (mode_w == pulse_width_trigger_mode && state_r == st_expose ##1 state_r == st_readout);
	c_soft_frame: cover property (mode_w == software_trigger_mode && soft_r && state_r == st_idle);
	c_lockout_hit: cover property (state_r != st_idle && edge_hit && sel);
endmodule
`default_nettype wire

// File: trig_source.sv
`default_nettype none
module trig_source (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       fire,
	input  wire logic [7:0] pulse_len,
	input  wire logic       readout_sync,
	output logic            trig_in_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_r;
	// pulse held low for pulse_len cycles; new pulse only while readout is low
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			cnt_r <= 8'h00;
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
		else if (fire && !readout_sync)
			cnt_r <= pulse_len;
	end
	// line driven high while the counter is zero, low means trigger
	assign trig_in_n = (cnt_r == 8'h00);
endmodule
`default_nettype wire

// File: tb_top.sv
`default_nettype none
module tb_top;
	import camtrig_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic              core_clk, arst_n, avs_read, avs_write, fire;
	logic [ADDR_W-1:0] avs_address;
	logic [31:0]       avs_writedata, avs_readdata, q;
	logic [3:0]        avs_byteenable;
	logic              avs_waitrequest, trig_in_n, readout_sync, status_sync;
	logic              pix_sof, pix_valid, pix_eol, bin_valid;
	logic [PIX_W-1:0]  pix_data;
	logic [SUM_W-1:0]  bin_data;
	logic [SUM_W-1:0]  binq[$];
	logic [PIX_W-1:0]  px[8];
	logic [7:0]        pulse_len;
	int                n_errors, tests_run, cycles, e, r, n, fc;
	camera_trigger_sync_port u_camera_trigger_sync_port (.core_clk(core_clk), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .trig_in_n(trig_in_n), .readout_sync(readout_sync),
		.status_sync(status_sync), .pix_sof(pix_sof), .pix_valid(pix_valid), .pix_data(pix_data),
		.pix_eol(pix_eol), .bin_valid(bin_valid), .bin_data(bin_data));
	trig_source u_trig_source (.core_clk(core_clk), .arst_n(arst_n), .fire(fire),
		.pulse_len(pulse_len), .readout_sync(readout_sync), .trig_in_n(trig_in_n));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic finish_test();
		$display("errors %0d, checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (bin_valid === 1'b1)
			binq.push_back(bin_data);
		if (cycles > 20000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic fire_t(input logic [7:0] len);
		pulse_len <= len;
		fire <= 1'b1;
		@(posedge core_clk);
		fire <= 1'b0;
	endtask
	function automatic logic sig(input bit which);
		return which ? readout_sync : status_sync;
	endfunction
	task automatic meas(input bit which, output int cnt);
		int w;
		cnt = 0;
		w = 0;
		while (sig(which) !== 1'b1 && w < 100) begin
			@(posedge core_clk);
			w++;
		end
		while (sig(which) === 1'b1 && cnt < 300) begin
			@(posedge core_clk);
			cnt++;
		end
	endtask
	function automatic logic [31:0] ctrl(input int bn, input int sl, input int pl, input int md);
		return 32'(bn * 16 + sl * 8 + pl * 4 + md);
	endfunction
	function automatic logic [SUM_W-1:0] bsum(input int i);
		return SUM_W'(px[i]) + SUM_W'(px[i + 1]) + SUM_W'(px[i + 4]) + SUM_W'(px[i + 5]);
	endfunction
	task automatic pix(input logic [PIX_W-1:0] d, input logic eol);
		pix_valid <= 1'b1;
		pix_data <= d;
		pix_eol <= eol;
		@(posedge core_clk);
	endtask
	initial begin
		{avs_read, avs_write, fire, pix_sof, pix_valid, pix_eol} = '0;
		{avs_address, avs_writedata, pix_data, pulse_len} = '0;
		avs_byteenable = 4'hF;
		n_errors = 0;
		tests_run = 0;
		cycles = 0;
		arst_n = 1'b0;
		void'($urandom(32'h63af));
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		bus(0, CTRL_OFS, 0);
		check("ctrl reset", q, 32'(CTRL_RST));
		bus(0, EXPO_OFS, 0);
		check("expo reset", q, 32'(EXPO_RST));
		bus(0, RDLEN_OFS, 0);
		check("rdlen reset", q, 32'(RDLEN_RST));
		bus(0, 5'h14, 0);
		check("unmapped", q, 32'h0000_0000);
		e = 2 + $urandom % 8;
		r = 2 + $urandom % 8;
		bus(1, EXPO_OFS, e);
		bus(1, RDLEN_OFS, r);
		bus(0, EXPO_OFS, 0);
		check("expo rw", q, e);
		for (int p = 0; p < 2; p++) begin
			bus(1, CTRL_OFS, ctrl(0, 0, p, 1));
			fire_t(8'h03);
			meas(0, n);
			check("edge expose", n, e);
			meas(1, n);
			check("readout", n, r);
		end
		bus(1, CTRL_OFS, ctrl(0, 1, 1, 1));
		fire_t(8'h01);
		fork
			meas(0, n);
			begin
				repeat (3) @(posedge core_clk);
				fire_t(8'h01);
			end
		join
		check("lockout", n, e + r);
		repeat (20) @(posedge core_clk);
		check("ignored", status_sync, 1'b0);
		repeat (3) begin
			bus(1, CTRL_OFS, ctrl(0, 0, 1, 2));
			n = 3 + $urandom % 20;
			fire_t(8'(n));
			meas(0, e);
			check("pulse", e, n);
			repeat (30) @(posedge core_clk);
		end
		bus(1, EXPO_OFS, 4);
		bus(1, CTRL_OFS, ctrl(0, 0, 1, 3));
		bus(0, STATUS_OFS, 0);
		fc = q[31:16];
		bus(1, SWTRIG_OFS, 0);
		repeat (20) @(posedge core_clk);
		check("sw bit0 low", status_sync, 1'b0);
		bus(1, SWTRIG_OFS, 1);
		meas(0, n);
		check("sw expose", n, 4);
		repeat (15) @(posedge core_clk);
		bus(0, STATUS_OFS, 0);
		check("frames", q[31:16], 16'(fc + 1));
		bus(1, CTRL_OFS, ctrl(1, 0, 1, 0));
		repeat (2) begin
			meas(0, n);
			check("free run", n, 4);
		end
		bus(1, CTRL_OFS, ctrl(1, 0, 1, 1));
		pix_sof <= 1'b1;
		@(posedge core_clk);
		pix_sof <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			px[i] = PIX_W'($urandom);
			pix(px[i], i % 4 == 3);
		end
		pix_valid <= 1'b0;
		pix_eol <= 1'b0;
		repeat (5) @(posedge core_clk);
		check("bin count", binq.size(), 2);
		for (int i = 0; i < 2 && i < binq.size(); i++)
			check("bin sum", binq[i], bsum(2 * i));
		finish_test();
	end
endmodule
`default_nettype wire
